// ### inc/otf_consts.svh
// Constants for the on-the-fly profile block.
// Assumes inclusion by bare name from any design or bench file.
`ifndef OTF_CONSTS_SVH
`define OTF_CONSTS_SVH
`define OTF_CLK_HZ       25000000
`define OTF_CLK_MHZ      25
`define OTF_TICK_US      1000
`define OTF_DIST_SCALE   2000
`define OTF_VEL_W        24
`define OTF_POS_W        32
`define OTF_TIME_W       16
`define OTF_DIV_STEPS    25
`define OTF_ACC_W        26
`endif

// ### inc/otf_pkg.sv
// Types for the on-the-fly profile block.
// Assumes nothing beyond a SystemVerilog compiler.
package otf_pkg;
   typedef enum logic [3:0] {
      CMD_NONE      = 4'h0,
      CMD_START_VEL = 4'h1,
      CMD_START_REL = 4'h2,
      CMD_START_ABS = 4'h3,
      CMD_V_CHANGE  = 4'h4,
      CMD_CMP_VCHG  = 4'h5,
      CMD_P_CHANGE  = 4'h6,
      CMD_SD_STOP   = 4'h7,
      CMD_EMG_STOP  = 4'h8,
      CMD_FIX_RANGE = 4'h9,
      CMD_UNFIX     = 4'hA
   } otf_cmd_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_DIV  = 2'b01,
      ST_RUN  = 2'b10
   } otf_state_t;
   typedef enum logic [1:0] {
      END_HOLD = 2'b00,
      END_STOP = 2'b01,
      END_REV  = 2'b10
   } otf_end_t;
endpackage

// ### src/otf_profile.sv
// Single-axis step-pulse profile generator with on-the-fly speed change and, in absolute moves only, target change; multi-axis moves allow neither.
// Assumes commands come from logic on sys_clk; cmp_match comes from outside and is synchronised.
`timescale 1ns/1ps
`include "otf_consts.svh"
module otf_profile #(
   parameter int TICK_CYCLES = (`OTF_CLK_MHZ * `OTF_TICK_US)
) (
   // Clock, reset, enable
   input  wire logic                          sys_clk,
   input  wire logic                          reset,
   input  wire logic                          ce,
   // Command port
   input  wire logic                          cmd_valid,
   input  otf_pkg::otf_cmd_t                  cmd_code,
   input  wire logic                          cmd_multi_axis,
   input  wire logic                          cmd_scurve,
   input  wire logic                          cmd_dir,
   input  wire logic [`OTF_VEL_W-1:0]         cmd_velocity,
   input  wire logic [`OTF_VEL_W-1:0]         cmd_start_velocity,
   input  wire logic [`OTF_TIME_W-1:0]        cmd_time,
   input  wire logic [`OTF_TIME_W-1:0]        cmd_decel_time,
   input  wire logic signed [`OTF_POS_W-1:0]  cmd_target,
   // Comparator condition
   input  wire logic                          cmp_match,
   // Answers and state
   output logic                               cmd_accept,
   output logic                               cmd_error,
   output logic                               busy,
   output logic [`OTF_VEL_W-1:0]              present_velocity,
   output logic signed [`OTF_POS_W-1:0]       present_position,
   // Drive pins
   output logic                               pulse_out,
   output logic                               dir_out
);
   otf_pkg::otf_state_t state_reg;
   otf_pkg::otf_end_t   end_reg;
   logic [`OTF_VEL_W-1:0]  vel_reg, start_v_reg, peak_reg, range_reg, rtgt_reg, step_reg, jerk_reg, inc_reg;
   logic [`OTF_VEL_W-1:0]  cmp_vel_reg;
   logic [`OTF_TIME_W-1:0] tacc_reg, tdec_reg, rtime_reg, rcnt_reg, cmp_time_reg;
   logic signed [`OTF_POS_W-1:0] pos_reg, target_reg;
   logic dir_reg, preset_reg, abs_reg, multi_reg, scurve_reg, fixed_reg, ramp_on_reg, decel_reg;
   logic cmp_pend_reg, cmp_meta_reg, cmp_sync_reg, cmp_last_reg;
   logic [`OTF_ACC_W-1:0] acc_reg;
   logic [31:0] tick_cnt_reg;
   logic        tick;
   logic [4:0]  div_cnt_reg;
   logic        div_pass_reg;
   logic [`OTF_VEL_W:0] div_dvd_reg, div_quo_reg;
   logic [`OTF_TIME_W:0] div_rem_reg;
   logic [`OTF_TIME_W:0] div_trial;
   // Derived tracking values.
   logic signed [`OTF_POS_W:0] diff, ndiff;
   logic [`OTF_POS_W-1:0] remain, nrem;
   logic [47:0] rem_sc, nrem_sc, vchg_need, dec_need, pk_need;
   logic running, cmp_fire, toward, go_ok, v_ok, p_ok, at_target;
   logic [`OTF_VEL_W-1:0] ceiling, chk_vel;
   logic [`OTF_TIME_W-1:0] chk_time;
   // Launch request for a new ramp.
   logic launch, l_decel;
   logic [`OTF_VEL_W-1:0] l_tgt;
   logic [`OTF_TIME_W-1:0] l_time;
   otf_pkg::otf_end_t l_end;
   logic [`OTF_VEL_W-1:0] vnew, inc;
   logic ramp_done;

   assign running = (state_reg != otf_pkg::ST_IDLE);
   assign diff   = {target_reg[`OTF_POS_W-1], target_reg} - {pos_reg[`OTF_POS_W-1], pos_reg};
   assign toward = dir_reg ? (diff > 0) : (diff < 0);
   assign remain = toward ? (diff[`OTF_POS_W] ? `OTF_POS_W'(-diff) : `OTF_POS_W'(diff)) : '0;
   assign ndiff  = {cmd_target[`OTF_POS_W-1], cmd_target} - {pos_reg[`OTF_POS_W-1], pos_reg};
   assign nrem   = ndiff[`OTF_POS_W] ? `OTF_POS_W'(-ndiff) : `OTF_POS_W'(ndiff);
   assign rem_sc  = 48'(remain) * 48'(`OTF_DIST_SCALE);
   assign nrem_sc = 48'(nrem) * 48'(`OTF_DIST_SCALE);
   assign at_target = preset_reg && (end_reg != otf_pkg::END_REV) && (diff == 0);
   assign ceiling  = fixed_reg ? range_reg : peak_reg;
   assign cmp_fire = cmp_pend_reg && cmp_sync_reg && !cmp_last_reg;
   assign chk_vel  = cmp_fire ? cmp_vel_reg : cmd_velocity;
   assign chk_time = cmp_fire ? cmp_time_reg : cmd_time;
   assign vchg_need = 48'(vel_reg + 25'(chk_vel)) * 48'(chk_time) + 48'(chk_vel) * 48'(tdec_reg);
   assign dec_need  = 48'(vel_reg) * 48'(tdec_reg);
   // Peak times deceleration time; the half is carried by the 2000 distance scale.
   assign pk_need   = 48'(peak_reg) * 48'(tdec_reg);
   assign go_ok = running && (end_reg == otf_pkg::END_HOLD) && !decel_reg;
   assign v_ok = go_ok && !multi_reg && (chk_vel != '0) && (chk_vel <= ceiling) && (!preset_reg || rem_sc >= vchg_need);
   assign p_ok = go_ok && !multi_reg && preset_reg && abs_reg && (nrem_sc >= pk_need);

   always_comb begin
      launch  = 1'b0;
      l_decel = 1'b0;
      l_tgt   = peak_reg;
      l_time  = tacc_reg;
      l_end   = otf_pkg::END_HOLD;
      if (cmd_valid && cmd_code == otf_pkg::CMD_V_CHANGE && v_ok) begin
         launch = 1'b1;
         l_tgt  = cmd_velocity;
         l_time = cmd_time;
      end else if (cmd_valid && cmd_code == otf_pkg::CMD_SD_STOP && running) begin
         launch  = 1'b1;
         l_decel = 1'b1;
         l_tgt   = start_v_reg;
         l_time  = tdec_reg;
         l_end   = otf_pkg::END_STOP;
      end else if (cmd_valid && cmd_code == otf_pkg::CMD_P_CHANGE && p_ok && (dir_reg ? ndiff < 0 : ndiff > 0)) begin
         launch = 1'b1;
         l_tgt  = start_v_reg;
         l_time = tdec_reg;
         l_end  = otf_pkg::END_REV;
      end else if (cmp_fire && v_ok) begin
         launch = 1'b1;
         l_tgt  = cmp_vel_reg;
         l_time = cmp_time_reg;
      end else if (state_reg == otf_pkg::ST_RUN && go_ok && preset_reg && rem_sc <= dec_need) begin
         launch  = 1'b1;
         l_decel = 1'b1;
         l_tgt   = start_v_reg;
         l_time  = tdec_reg;
      end
   end

   assign inc = scurve_reg ? inc_reg : step_reg;
   always_comb begin
      vnew = vel_reg;
      if (vel_reg < rtgt_reg) begin
         vnew = (rtgt_reg - vel_reg <= inc) ? rtgt_reg : vel_reg + inc;
      end else if (vel_reg > rtgt_reg) begin
         vnew = (vel_reg - rtgt_reg <= inc) ? rtgt_reg : vel_reg - inc;
      end
   end
   assign ramp_done = (vnew == rtgt_reg);
   assign div_trial = {div_rem_reg[`OTF_TIME_W-1:0], div_dvd_reg[`OTF_VEL_W]};

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         tick_cnt_reg <= '0;
      end else if (ce) begin
         tick_cnt_reg <= tick ? '0 : tick_cnt_reg + 32'h1;
      end
   end
   assign tick = (tick_cnt_reg == 32'(TICK_CYCLES - 1));

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         cmp_meta_reg <= 1'b0;
         cmp_sync_reg <= 1'b0;
         cmp_last_reg <= 1'b0;
      end else if (ce) begin
         cmp_meta_reg <= cmp_match;
         cmp_sync_reg <= cmp_meta_reg;
         cmp_last_reg <= cmp_sync_reg;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state_reg <= otf_pkg::ST_IDLE;
         end_reg <= otf_pkg::END_HOLD;
         vel_reg <= '0;
         start_v_reg <= '0;
         peak_reg <= '0;
         range_reg <= '0;
         rtgt_reg <= '0;
         step_reg <= '0;
         jerk_reg <= '0;
         inc_reg <= '0;
         cmp_vel_reg <= '0;
         tacc_reg <= '0;
         tdec_reg <= '0;
         rtime_reg <= '0;
         rcnt_reg <= '0;
         cmp_time_reg <= '0;
         target_reg <= '0;
         dir_reg <= 1'b1;
         preset_reg <= 1'b0;
         abs_reg <= 1'b0;
         multi_reg <= 1'b0;
         scurve_reg <= 1'b0;
         fixed_reg <= 1'b0;
         ramp_on_reg <= 1'b0;
         decel_reg <= 1'b0;
         cmp_pend_reg <= 1'b0;
         div_cnt_reg <= '0;
         div_pass_reg <= 1'b0;
         div_dvd_reg <= '0;
         div_quo_reg <= '0;
         div_rem_reg <= '0;
         cmd_accept <= 1'b0;
         cmd_error <= 1'b0;
      end else if (ce) begin
         cmd_accept <= 1'b0;
         cmd_error <= 1'b0;
         if (cmd_valid) begin
            case (cmd_code)
               otf_pkg::CMD_START_VEL, otf_pkg::CMD_START_REL, otf_pkg::CMD_START_ABS: begin
                  if (!running) begin
                     start_v_reg <= cmd_start_velocity;
                     vel_reg <= cmd_start_velocity;
                     peak_reg <= cmd_velocity;
                     tacc_reg <= cmd_time;
                     tdec_reg <= cmd_decel_time;
                     scurve_reg <= cmd_scurve;
                     multi_reg <= cmd_multi_axis;
                     preset_reg <= (cmd_code != otf_pkg::CMD_START_VEL);
                     abs_reg <= (cmd_code == otf_pkg::CMD_START_ABS);
                     decel_reg <= 1'b0;
                     cmp_pend_reg <= 1'b0;
                     if (cmd_code == otf_pkg::CMD_START_ABS) begin
                        target_reg <= cmd_target;
                        dir_reg <= (cmd_target >= pos_reg);
                     end else if (cmd_code == otf_pkg::CMD_START_REL) begin
                        target_reg <= pos_reg + cmd_target;
                        dir_reg <= !cmd_target[`OTF_POS_W-1];
                     end else begin
                        dir_reg <= cmd_dir;
                     end
                  end
                  cmd_accept <= !running;
                  cmd_error <= running;
               end
               otf_pkg::CMD_V_CHANGE: begin
                  cmd_accept <= v_ok;
                  cmd_error <= !v_ok;
               end
               otf_pkg::CMD_SD_STOP: begin
                  cmd_accept <= running;
                  cmd_error <= !running;
               end
               otf_pkg::CMD_CMP_VCHG: begin
                  cmd_accept <= v_ok;
                  cmd_error <= !v_ok;
                  cmp_pend_reg <= v_ok;
                  cmp_vel_reg <= cmd_velocity;
                  cmp_time_reg <= cmd_time;
               end
               otf_pkg::CMD_P_CHANGE: begin
                  if (p_ok) begin
                     target_reg <= cmd_target;
                  end
                  cmd_accept <= p_ok;
                  cmd_error <= !p_ok;
               end
               otf_pkg::CMD_FIX_RANGE: begin
                  range_reg <= cmd_velocity;
                  fixed_reg <= 1'b1;
                  cmd_accept <= 1'b1;
               end
               otf_pkg::CMD_UNFIX: begin
                  fixed_reg <= 1'b0;
                  cmd_accept <= 1'b1;
               end
               otf_pkg::CMD_EMG_STOP: begin
                  cmd_accept <= 1'b1;
               end
               default: begin
                  cmd_error <= 1'b1;
               end
            endcase
         end
         if (cmp_fire) begin
            cmp_pend_reg <= 1'b0;
         end
         case (state_reg)
            otf_pkg::ST_DIV: begin
               if (div_cnt_reg != '0) begin
                  div_cnt_reg <= div_cnt_reg - 5'h1;
                  div_dvd_reg <= {div_dvd_reg[`OTF_VEL_W-1:0], 1'b0};
                  div_quo_reg <= {div_quo_reg[`OTF_VEL_W-1:0], div_trial >= {1'b0, rtime_reg}};
                  div_rem_reg <= (div_trial >= {1'b0, rtime_reg}) ? div_trial - {1'b0, rtime_reg} : div_trial;
               end else if (!div_pass_reg && scurve_reg) begin
                  // Jerk comes from a second pass; the peak step is twice the mean.
                  step_reg <= (div_quo_reg == '0) ? `OTF_VEL_W'(1) : div_quo_reg[`OTF_VEL_W-1:0];
                  div_pass_reg <= 1'b1;
                  div_dvd_reg <= {div_quo_reg[`OTF_VEL_W-1:0], 1'b0};
                  div_rem_reg <= '0;
                  div_quo_reg <= '0;
                  div_cnt_reg <= 5'(`OTF_DIV_STEPS);
               end else begin
                  if (div_pass_reg) begin
                     jerk_reg <= (div_quo_reg == '0) ? `OTF_VEL_W'(1) : div_quo_reg[`OTF_VEL_W-1:0];
                     inc_reg <= (div_quo_reg == '0) ? `OTF_VEL_W'(1) : div_quo_reg[`OTF_VEL_W-1:0];
                  end else begin
                     step_reg <= (div_quo_reg == '0) ? `OTF_VEL_W'(1) : div_quo_reg[`OTF_VEL_W-1:0];
                  end
                  rcnt_reg <= '0;
                  ramp_on_reg <= 1'b1;
                  state_reg <= otf_pkg::ST_RUN;
               end
            end
            otf_pkg::ST_RUN: begin
               // Ramp paced by the one-millisecond tick.
               if (tick && ramp_on_reg) begin
                  vel_reg <= vnew;
                  rcnt_reg <= rcnt_reg + 16'h1;
                  if (rcnt_reg < (rtime_reg >> 1)) begin
                     inc_reg <= inc_reg + jerk_reg;
                  end else if (inc_reg > jerk_reg) begin
                     inc_reg <= inc_reg - jerk_reg;
                  end
                  if (ramp_done) begin
                     ramp_on_reg <= 1'b0;
                     if (end_reg == otf_pkg::END_STOP) begin
                        state_reg <= otf_pkg::ST_IDLE;
                        vel_reg <= '0;
                     end else if (end_reg == otf_pkg::END_REV) begin
                        // Restart toward the new target at the original rates.
                        dir_reg <= !dir_reg;
                        end_reg <= otf_pkg::END_HOLD;
                        vel_reg <= start_v_reg;
                        rtgt_reg <= peak_reg;
                        rtime_reg <= (tacc_reg == '0) ? 16'h1 : tacc_reg;
                        div_dvd_reg <= scurve_reg ? {peak_reg - start_v_reg, 1'b0} : {1'b0, peak_reg - start_v_reg};
                        div_rem_reg <= '0;
                        div_quo_reg <= '0;
                        div_pass_reg <= 1'b0;
                        div_cnt_reg <= 5'(`OTF_DIV_STEPS);
                        state_reg <= otf_pkg::ST_DIV;
                     end
                  end
               end
            end
            default: begin
               ramp_on_reg <= 1'b0;
            end
         endcase
         if (launch || (cmd_valid && !running && cmd_code inside {otf_pkg::CMD_START_VEL,
               otf_pkg::CMD_START_REL, otf_pkg::CMD_START_ABS})) begin
            rtgt_reg <= running ? l_tgt : cmd_velocity;
            rtime_reg <= ((running ? l_time : cmd_time) == '0) ? 16'h1 : (running ? l_time : cmd_time);
            end_reg <= running ? l_end : otf_pkg::END_HOLD;
            if (running && l_decel) begin
               decel_reg <= 1'b1;
            end
            div_dvd_reg <= ((running ? l_tgt : cmd_velocity) > (running ? vel_reg : cmd_start_velocity)) ?
               25'((running ? l_tgt : cmd_velocity) - (running ? vel_reg : cmd_start_velocity)) << scurve_reg :
               25'((running ? vel_reg : cmd_start_velocity) - (running ? l_tgt : cmd_velocity)) << scurve_reg;
            div_rem_reg <= '0;
            div_quo_reg <= '0;
            div_pass_reg <= 1'b0;
            div_cnt_reg <= 5'(`OTF_DIV_STEPS);
            ramp_on_reg <= 1'b0;
            state_reg <= otf_pkg::ST_DIV;
         end
         // Immediate halt and end of preset travel.
         if ((cmd_valid && cmd_code == otf_pkg::CMD_EMG_STOP) || (running && at_target)) begin
            state_reg <= otf_pkg::ST_IDLE;
            vel_reg <= '0;
            ramp_on_reg <= 1'b0;
            cmp_pend_reg <= 1'b0;
         end
      end
   end

   // Pulses stop at the target so a late state update cannot overshoot.
   // A pulse waits one cycle after a direction flip so the drive sees direction settle first.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         acc_reg <= '0;
         pos_reg <= '0;
         pulse_out <= 1'b0;
         dir_out <= 1'b1;
         busy <= 1'b0;
         present_velocity <= '0;
      end else if (ce) begin
         busy <= running;
         present_velocity <= vel_reg;
         dir_out <= dir_reg;
         pulse_out <= 1'b0;
         if (running && !at_target && (dir_out == dir_reg)) begin
            if (acc_reg + `OTF_ACC_W'(vel_reg) >= `OTF_ACC_W'(`OTF_CLK_HZ)) begin
               acc_reg <= acc_reg + `OTF_ACC_W'(vel_reg) - `OTF_ACC_W'(`OTF_CLK_HZ);
               pulse_out <= 1'b1;
               pos_reg <= dir_reg ? pos_reg + 32'sh1 : pos_reg - 32'sh1;
            end else begin
               acc_reg <= acc_reg + `OTF_ACC_W'(vel_reg);
            end
         end else begin
            acc_reg <= '0;
         end
      end
   end
   assign present_position = pos_reg;
endmodule

// ### test/otf_profile_assertions.sv
// Concurrent checks on command answers and step output of the profile block.
// Assumes it is bound to otf_profile and sees only its ports.
`timescale 1ns/1ps
`include "otf_consts.svh"
module otf_profile_assertions (
   // Clock and reset
   input wire logic                         sys_clk,
   input wire logic                         reset,
   // Command port
   input wire logic                         cmd_valid,
   input otf_pkg::otf_cmd_t                 cmd_code,
   input wire logic                         cmd_accept,
   input wire logic                         cmd_error,
   // State and drive pins
   input wire logic                         busy,
   input wire logic signed [`OTF_POS_W-1:0] present_position,
   input wire logic                         pulse_out,
   input wire logic                         dir_out
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   a_one_answer: assert property (cmd_valid |=> cmd_accept != cmd_error)
      else $error("command answer missing or doubled");
   a_no_stray_answer: assert property (!$past(cmd_valid) |-> !cmd_accept && !cmd_error)
      else $error("answer without command");
   a_idle_refused: assert property (cmd_valid && cmd_code inside {otf_pkg::CMD_V_CHANGE,
      otf_pkg::CMD_P_CHANGE, otf_pkg::CMD_SD_STOP} ##1 !busy |-> cmd_error)
      else $error("change taken while idle");
   a_always_taken: assert property (cmd_valid && cmd_code inside {otf_pkg::CMD_FIX_RANGE,
      otf_pkg::CMD_UNFIX, otf_pkg::CMD_EMG_STOP} |=> cmd_accept)
      else $error("range or halt command refused");
   a_halt_fast: assert property (cmd_valid && cmd_code == otf_pkg::CMD_EMG_STOP
      |-> ##[1:3] (!busy && !pulse_out))
      else $error("immediate halt too slow");
   a_no_idle_pulse: assert property (!busy |-> !pulse_out)
      else $error("pulse while idle");
   a_single_pulse: assert property (pulse_out |=> !pulse_out)
      else $error("pulse longer than one cycle");
   a_step_counted: assert property (pulse_out |->
      present_position == $past(present_position) + (dir_out ? 32'sh1 : -32'sh1))
      else $error("position not stepped by pulse");
   a_pos_hold: assert property (!pulse_out |-> $stable(present_position))
      else $error("position moved without pulse");
   a_dir_steady: assert property (pulse_out |-> $stable(dir_out))
      else $error("direction changed with pulse");
endmodule

// ### test/otf_drive_model.sv
// Motor drive model that counts steps and direction reversals.
// Assumes step and direction come as registered signals on sys_clk.
`timescale 1ns/1ps
`include "otf_consts.svh"
module otf_drive_model (
   // Clock and reset
   input  wire logic                         sys_clk,
   input  wire logic                         reset,
   // Step and direction pins
   input  wire logic                         pulse_out,
   input  wire logic                         dir_out,
   // Observed motion
   output logic signed [`OTF_POS_W-1:0]      shaft_pos,
   output logic [7:0]                        reversals
);
   logic last_dir_reg;
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         shaft_pos    <= 32'sh0;
         reversals    <= 8'h00;
         last_dir_reg <= 1'b1;
      end else if (pulse_out) begin
         shaft_pos    <= shaft_pos + (dir_out ? 32'sh1 : -32'sh1);
         last_dir_reg <= dir_out;
         if (dir_out != last_dir_reg) begin
            reversals <= reversals + 8'h01;
         end
      end
   end
endmodule

// ### test/tb_on_the_fly_profile.sv
// Self-checking bench for the on-the-fly profile block with a drive model.
// Assumes a short tick; distances stay real, so moves are sized to keep runs short.
`timescale 1ns/1ps
`include "otf_consts.svh"
module tb_on_the_fly_profile;
   localparam int TICK = 50;
   localparam int RAMP = 3 * TICK + 40;
   localparam logic [23:0] PEAK = 24'h1E8480;
   logic sys_clk, reset, ce, cmd_valid, cmd_multi_axis, cmd_scurve, cmd_dir, cmp_match;
   logic cmd_accept, cmd_error, busy, pulse_out, dir_out;
   otf_pkg::otf_cmd_t cmd_code;
   logic [23:0] cmd_velocity, cmd_start_velocity, present_velocity;
   logic [15:0] cmd_time, cmd_decel_time;
   logic signed [31:0] cmd_target, present_position, shaft_pos, base, tgt;
   logic [7:0] reversals, rev0;
   int n_mismatch, check_count, waited;
   otf_profile #(.TICK_CYCLES(TICK)) otf_profile_i (.sys_clk(sys_clk), .reset(reset), .ce(ce),
      .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_multi_axis(cmd_multi_axis),
      .cmd_scurve(cmd_scurve), .cmd_dir(cmd_dir), .cmd_velocity(cmd_velocity),
      .cmd_start_velocity(cmd_start_velocity), .cmd_time(cmd_time), .cmd_decel_time(cmd_decel_time),
      .cmd_target(cmd_target), .cmp_match(cmp_match), .cmd_accept(cmd_accept), .cmd_error(cmd_error),
      .busy(busy), .present_velocity(present_velocity), .present_position(present_position),
      .pulse_out(pulse_out), .dir_out(dir_out));
   otf_drive_model otf_drive_model_i (.sys_clk(sys_clk), .reset(reset), .pulse_out(pulse_out),
      .dir_out(dir_out), .shaft_pos(shaft_pos), .reversals(reversals));
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic cmd(input otf_pkg::otf_cmd_t code, input logic [23:0] vel, input logic [15:0] tim,
                      input logic signed [31:0] tg, input logic ok);
      @(negedge sys_clk);
      cmd_code = code;
      cmd_velocity = vel;
      cmd_time = tim;
      cmd_target = tg;
      cmd_valid = 1'b1;
      @(negedge sys_clk);
      cmd_valid = 1'b0;
      chk("cmd_accept", {31'h0, ok}, {31'h0, cmd_accept});
      chk("cmd_error", {31'h0, !ok}, {31'h0, cmd_error});
   endtask
   // Kinds: 0 idle, 1 position at least, 2 velocity equal, 3 position at most.
   task automatic wait_for(input int kind, input logic signed [31:0] v);
      logic hit;
      waited = 0;
      do begin
         @(negedge sys_clk);
         waited++;
         case (kind)
            0: hit = (busy === 1'b0);
            1: hit = (present_position >= v);
            2: hit = (present_velocity === v[23:0]);
            default: hit = (present_position <= v);
         endcase
      end while (!hit && waited < 60000);
      if (!hit) begin
         n_mismatch++;
         $display("Error wait %0d expected %0d seen timeout", kind, v);
         complete_run();
      end
   endtask
   task automatic t_idle();
      cmd(otf_pkg::CMD_V_CHANGE, PEAK, 16'h0001, 32'sh0, 1'b0);
      cmd(otf_pkg::CMD_P_CHANGE, PEAK, 16'h0001, 32'sh1388, 1'b0);
      cmd(otf_pkg::CMD_SD_STOP, PEAK, 16'h0001, 32'sh0, 1'b0);
      cmd(otf_pkg::CMD_UNFIX, PEAK, 16'h0001, 32'sh0, 1'b1);
      $display("test idle done");
   endtask
   task automatic t_vel();
      cmd(otf_pkg::CMD_START_VEL, PEAK, 16'h0001, 32'sh0, 1'b1);
      wait_for(2, 32'(PEAK));
      cmd(otf_pkg::CMD_V_CHANGE, 24'h2DC6C0, 16'h0001, 32'sh0, 1'b0);
      cmd(otf_pkg::CMD_P_CHANGE, PEAK, 16'h0001, 32'sh7530, 1'b0);
      cmd(otf_pkg::CMD_V_CHANGE, 24'h1B7740, 16'h0002, 32'sh0, 1'b1);
      wait_for(2, 32'h1B7740);
      chk("ramp cycles", 32'h1, 32'(waited <= RAMP));
      cmd(otf_pkg::CMD_CMP_VCHG, 24'h1CFDE0, 16'h0001, 32'sh0, 1'b1);
      repeat (100) @(negedge sys_clk);
      chk("armed velocity", 32'h1B7740, 32'(present_velocity));
      cmp_match = 1'b1;
      wait_for(2, 32'h1CFDE0);
      chk("compare ramp cycles", 32'h1, 32'(waited <= RAMP));
      cmp_match = 1'b0;
      cmd(otf_pkg::CMD_SD_STOP, PEAK, 16'h0001, 32'sh0, 1'b1);
      wait_for(0, 32'sh0);
      chk("slow stop cycles", 32'h1, 32'(waited <= 4 * TICK));
      cmd_multi_axis = 1'b1;
      cmd_dir = 1'b0;
      cmd(otf_pkg::CMD_START_VEL, PEAK, 16'h0001, 32'sh0, 1'b1);
      cmd(otf_pkg::CMD_V_CHANGE, 24'h1B7740, 16'h0001, 32'sh0, 1'b0);
      cmd(otf_pkg::CMD_EMG_STOP, PEAK, 16'h0001, 32'sh0, 1'b1);
      cmd_multi_axis = 1'b0;
      cmd_dir = 1'b1;
      $display("test velocity done");
   endtask
   task automatic t_pos();
      base = present_position;
      cmd(otf_pkg::CMD_START_ABS, PEAK, 16'h0001, base + 32'sh7530, 1'b1);
      wait_for(2, 32'(PEAK));
      cmd(otf_pkg::CMD_P_CHANGE, PEAK, 16'h0001, present_position + 32'sh1F4, 1'b0);
      tgt = present_position + 32'sh5DC;
      cmd(otf_pkg::CMD_P_CHANGE, PEAK, 16'h0001, tgt, 1'b1);
      chk("peak kept", 32'(PEAK), 32'(present_velocity));
      wait_for(1, tgt - 32'sh384);
      cmd(otf_pkg::CMD_P_CHANGE, PEAK, 16'h0001, tgt + 32'sh1388, 1'b0);
      wait_for(0, 32'sh0);
      chk("final position", tgt, present_position);
      chk("drive position", tgt, shaft_pos);
      $display("test position done");
   endtask
   task automatic t_rev();
      cmd_scurve = 1'b1;
      base = present_position;
      cmd(otf_pkg::CMD_START_ABS, PEAK, 16'h0001, base + 32'sh7530, 1'b1);
      wait_for(1, base + 32'sh514);
      rev0 = reversals;
      cmd(otf_pkg::CMD_P_CHANGE, PEAK, 16'h0001, base + 32'sh32, 1'b1);
      wait_for(3, base + 32'sh4B0);
      chk("reverse direction", 32'h0, 32'(dir_out));
      chk("peak after reverse", 32'(PEAK), 32'(present_velocity));
      wait_for(0, 32'sh0);
      chk("back position", base + 32'sh32, present_position);
      chk("reversals", 32'(rev0 + 8'h01), 32'(reversals));
      cmd_scurve = 1'b0;
      $display("test reverse done");
   endtask
   task automatic t_preset();
      cmd(otf_pkg::CMD_FIX_RANGE, 24'h7A1200, 16'h0001, 32'sh0, 1'b1);
      cmd(otf_pkg::CMD_START_REL, PEAK, 16'h0001, 32'sh5DC, 1'b1);
      wait_for(2, 32'(PEAK));
      cmd(otf_pkg::CMD_V_CHANGE, 24'h3D0900, 16'h0001, 32'sh0, 1'b0);
      chk("velocity kept", 32'(PEAK), 32'(present_velocity));
      cmd(otf_pkg::CMD_EMG_STOP, PEAK, 16'h0001, 32'sh0, 1'b1);
      wait_for(0, 32'sh0);
      cmd(otf_pkg::CMD_UNFIX, PEAK, 16'h0001, 32'sh0, 1'b1);
      $display("test preset done");
   endtask
   initial begin
      ce = 1'b1;
      reset = 1'b1;
      cmd_valid = 1'b0;
      cmd_code = otf_pkg::CMD_NONE;
      cmd_multi_axis = 1'b0;
      cmd_scurve = 1'b0;
      cmd_dir = 1'b1;
      cmp_match = 1'b0;
      cmd_velocity = 24'h0;
      cmd_start_velocity = 24'h186A00;
      cmd_time = 16'h0001;
      cmd_decel_time = 16'h0001;
      cmd_target = 32'sh0;
      n_mismatch = 0;
      check_count = 0;
      repeat (20) @(negedge sys_clk);
      chk("reset position", 32'h0, present_position);
      reset = 1'b0;
      t_idle();
      t_vel();
      t_pos();
      t_rev();
      t_preset();
      complete_run();
   end
endmodule
bind otf_profile otf_profile_assertions otf_profile_assertions_i (.sys_clk(sys_clk), .reset(reset),
   .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_accept(cmd_accept), .cmd_error(cmd_error),
   .busy(busy), .present_position(present_position), .pulse_out(pulse_out), .dir_out(dir_out));
